// File: common/atf_cfg.svh
`ifndef ATF_CFG_SVH
`define ATF_CFG_SVH

// Register bus geometry
`define ATF_ADDR_W      6
`define ATF_DATA_W      8
`define ATF_RES_W       10

// Register offsets
`define ATF_OFS_PIN_OFF 6'h01
`define ATF_OFS_CTRL_B  6'h03
`define ATF_OFS_RES_LO  6'h04
`define ATF_OFS_RES_HI  6'h05
`define ATF_OFS_CTRL_A  6'h06

// Control register A fields
`define ATF_A_ENABLE    7
`define ATF_A_START     6
`define ATF_A_AUTO      5
`define ATF_A_DONE      4
`define ATF_A_IE        3
`define ATF_A_PRESC     2:0

// Control register B fields
`define ATF_B_BIPOLAR   7
`define ATF_B_CMP_MUX   6
`define ATF_B_RESV_HI   5
`define ATF_B_LEFT      4
`define ATF_B_RESV_LO   3
`define ATF_B_SEL       2:0

// Trigger source codes
`define ATF_SEL_FREE    3'h0
`define ATF_SEL_CMP     3'h1
`define ATF_SEL_EXT0    3'h2
`define ATF_SEL_T0CMPA  3'h3
`define ATF_SEL_T0OVF   3'h4
`define ATF_SEL_T1CMPB  3'h5
`define ATF_SEL_T1OVF   3'h6
`define ATF_SEL_T1CAP   3'h7

// Reset values
`define ATF_RST_BYTE    8'h00
`define ATF_RST_RES     10'h000

`endif

// File: common/atf_pkg.sv
`include "atf_cfg.svh"

package atf_pkg;

    // One register bus request
    typedef struct packed {
        logic [`ATF_ADDR_W-1:0] addr;
        logic [`ATF_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } atf_bus_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [7:0]  pin_off;
        logic [9:0]  result;
        logic        locked;
        logic        prev_trig;
        logic [2:0]  prev_sel;
        logic        start;
        logic [7:0]  rdata;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
        logic [7:0]  pin_rd;
    } atf_state_t;

endpackage : atf_pkg

// File: tb/atf_conv_model.sv
`include "atf_cfg.svh"

// Far side: trigger sources and converter core
module atf_conv_model #(
    parameter int LAT = 4
) (
    input  wire logic                  clock_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  start_in,
    input  wire logic                  enable_in,
    input  wire logic [`ATF_RES_W-1:0] result_req_in,
    input  wire logic [7:1]            flag_req_in,
    output logic      [7:1]            trig_flags_out,
    output logic                       conv_done_out,
    output logic      [`ATF_RES_W-1:0] conv_result_out
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt_r;

    // Flags change on clock like real timer and comparator flags
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            trig_flags_out  <= 7'h00;
            conv_done_out   <= 1'b0;
            conv_result_out <= 10'h3FF;
            cnt_r           <= 0;
        end else begin
            trig_flags_out <= flag_req_in;
            conv_done_out  <= enable_in && cnt_r == 1;
            // Result only valid with done; garbage otherwise
            conv_result_out <= (enable_in && cnt_r == 1) ? result_req_in
                                                         : ~conv_result_out;
            if (!enable_in) begin
                cnt_r <= 0;     // Disable aborts conversion
            end else if (start_in) begin
                cnt_r <= LAT;
            end else if (cnt_r > 0) begin
                cnt_r <= cnt_r - 1;
            end
        end
    end
endmodule : atf_conv_model

// File: tb/testbench.sv
`include "atf_cfg.svh"

module testbench
    import atf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clock_in, reset_n_in, wr, rd, start, enable, done, flag_done;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, pins, pin_rd, pin_off;
    logic [7:1] flags, flag_req;
    logic [9:0] res, res_req;
    logic       bipolar, cmp_mux;
    logic [2:0] presc;
    int         bad_count, n_checks, n_starts;

    atf_top u_atf_top (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr),
        .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
        .trig_flags_in(flags), .conv_done_in(done), .conv_result_in(res),
        .conv_enable_out(enable), .conv_start_out(start),
        .conv_prescale_out(presc), .conv_bipolar_out(bipolar),
        .comparator_mux_select_out(cmp_mux),
        .conversion_done_flag_out(flag_done),
        .pin_level_in(pins), .analog_pin_input_off_out(pin_off),
        .pin_read_out(pin_rd));

    atf_conv_model u_atf_conv_model (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .start_in(start),
        .enable_in(enable), .result_req_in(res_req),
        .flag_req_in(flag_req), .trig_flags_out(flags),
        .conv_done_out(done), .conv_result_out(res));

    // Clock, 10 ns period
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // Count start pulses seen by the converter
    always @(posedge clock_in) begin
        if (start === 1'b1) n_starts++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_in);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe edge
    task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_in);
        rd   <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd_reg

    // Fixed window long enough for start plus a whole conversion
    task automatic expect_starts(input int exp);
        int s0;
        s0 = n_starts;
        repeat (12) @(posedge clock_in);
        chk(16'(n_starts - s0), 16'(exp));
    endtask : expect_starts

    task automatic regs_check();
        rd_reg(`ATF_OFS_PIN_OFF, 8'h00);
        rd_reg(`ATF_OFS_CTRL_B, 8'h00);
        rd_reg(6'h3F, 8'h00);               // Unmapped address
        wr_reg(`ATF_OFS_CTRL_B, 8'hE8);
        rd_reg(`ATF_OFS_CTRL_B, 8'hE8);
        chk({bipolar, cmp_mux}, 2'h3);
        wr_reg(`ATF_OFS_CTRL_B, 8'h00);
        wr_reg(`ATF_OFS_CTRL_A, 8'h8F);
        rd_reg(`ATF_OFS_CTRL_A, 8'h8F);
        chk({enable, presc}, 4'hF);
        wr_reg(`ATF_OFS_CTRL_A, 8'h00);
    endtask : regs_check

    task automatic pins_check();
        pins <= 8'hFF;
        wr_reg(`ATF_OFS_PIN_OFF, 8'h0F);    // Unused analog pins off
        repeat (4) @(posedge clock_in);
        chk(pin_off, 8'h0F);
        chk(pin_rd, 8'hF0);
        rd_reg(`ATF_OFS_PIN_OFF, 8'h0F);
    endtask : pins_check

    // Source codes 1 to 7, each followed by a done flag clear
    task automatic sources_check();
        wr_reg(`ATF_OFS_CTRL_A, 8'hA0);
        for (int s = 1; s < 8; s++) begin
            wr_reg(`ATF_OFS_CTRL_B, 8'(s));
            flag_req <= 7'(1 << (s - 1));
            expect_starts(1);
            flag_req <= 7'h00;
            wr_reg(`ATF_OFS_CTRL_A, 8'hB0);
        end
        wr_reg(`ATF_OFS_CTRL_A, 8'h80);
        wr_reg(`ATF_OFS_CTRL_B, 8'h01);
        flag_req <= 7'h01;
        expect_starts(0);
        flag_req <= 7'h00;
    endtask : sources_check

    task automatic switch_check();
        wr_reg(`ATF_OFS_CTRL_A, 8'hA0);
        flag_req <= 7'h02;
        repeat (3) @(posedge clock_in);
        wr_reg(`ATF_OFS_CTRL_B, 8'h02);
        expect_starts(1);
        chk(flag_done, 1'b1);
        // Old source low, done flag high: only the guard stops a start
        flag_req <= 7'h00;
        repeat (3) @(posedge clock_in);
        wr_reg(`ATF_OFS_CTRL_B, 8'h00);
        expect_starts(0);
        wr_reg(`ATF_OFS_CTRL_A, 8'h90);
    endtask : switch_check

    task automatic align_check();
        res_req <= 10'h2B5;
        wr_reg(`ATF_OFS_CTRL_A, 8'hC0);     // Software start
        expect_starts(1);
        rd_reg(`ATF_OFS_RES_LO, 8'hB5);
        rd_reg(`ATF_OFS_RES_HI, 8'h02);
        wr_reg(`ATF_OFS_CTRL_B, 8'h10);
        rd_reg(`ATF_OFS_RES_HI, 8'hAD);
        rd_reg(`ATF_OFS_RES_LO, 8'h40);
        res_req <= 10'h155;
        wr_reg(`ATF_OFS_CTRL_A, 8'hD0);
        expect_starts(1);
        rd_reg(`ATF_OFS_RES_HI, 8'hAD);     // Pair held by low read
        // Busy converter: flip alignment, read high byte next cycle
        wr_reg(`ATF_OFS_CTRL_A, 8'hD0);
        @(posedge clock_in);
        addr  <= `ATF_OFS_CTRL_B;
        wdata <= 8'h00;
        wr    <= 1'b1;
        @(posedge clock_in);
        wr    <= 1'b0;
        addr  <= `ATF_OFS_RES_HI;
        rd    <= 1'b1;
        @(posedge clock_in);
        rd    <= 1'b0;
        #1 chk(rdata, 8'h02);
        repeat (8) @(posedge clock_in);
        rd_reg(`ATF_OFS_RES_HI, 8'h01);     // Freed pair takes result
    endtask : align_check

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // Hang guard: counts as a mismatch
    initial begin
        #500us;
        bad_count++;
        conclude();
    end

    initial begin
        reset_n_in = 1'b0;
        {wr, rd, addr, wdata, pins, flag_req, res_req} = '0;
        bad_count = 0;
        n_checks  = 0;
        n_starts  = 0;
        repeat (10) @(posedge clock_in);
        reset_n_in <= 1'b1;
        regs_check();
        pins_check();
        sources_check();
        switch_check();
        align_check();
        conclude();
    end
endmodule : testbench

// File: verilog/atf_top.sv
//
// Contract
// (R1) Alignment bit picks left or right result
// (R2) Alignment change shows in result at once
// (R3) Reserved control bits 5, 3 store writes
// (R4) Source field matters only with auto trigger
// (R5) Auto mode starts on selected flag rise
// (R6) Switching low to high source triggers
// (R7) Switching to free running never triggers
// (R8) Source codes map to eight trigger flags
// (R9) Disable bit switches off pin input buffer
// (R10) Disabled pin reads zero in port input
// (R11) Software disables unused analog pin buffers
// (R12) Auto enable starts on positive trigger edge
// (R13) Result byte layouts per alignment
// (R14) Low read locks pair until high read
// (R15) Registered flag copy gives edge detect
//
`include "atf_cfg.svh"

module atf_top
    import atf_pkg::*;
(
    input  wire logic                   clock_in,
    input  wire logic                   reset_n_in,
    input  wire logic [`ATF_ADDR_W-1:0] addr_in,
    input  wire logic [`ATF_DATA_W-1:0] wr_data_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic      [`ATF_DATA_W-1:0] rd_data_out,
    input  wire logic [7:1]             trig_flags_in,
    input  wire logic                   conv_done_in,
    input  wire logic [`ATF_RES_W-1:0]  conv_result_in,
    output logic                        conv_enable_out,
    output logic                        conv_start_out,
    output logic      [2:0]             conv_prescale_out,
    output logic                        conv_bipolar_out,
    output logic                        comparator_mux_select_out,
    output logic                        conversion_done_flag_out,
    input  wire logic [7:0]             pin_level_in,
    output logic      [7:0]             analog_pin_input_off_out,
    output logic      [7:0]             pin_read_out
);

    atf_bus_t   bus;
    atf_state_t st_r;
    atf_state_t st_nxt;
    logic       trig_cur;
    logic       to_free;
    logic       trig_fire;
    logic       sw_start;
    logic [7:0] res_hi;
    logic [7:0] res_lo;

    // Bus signals travel together
    assign bus = '{addr: addr_in, wdata: wr_data_in, wr: wr_in, rd: rd_in};

    // Selected trigger flag; free running watches the done flag
    always_comb begin
        unique case (st_r.ctrl_b[`ATF_B_SEL])
            `ATF_SEL_FREE:   trig_cur = st_r.ctrl_a[`ATF_A_DONE]; // [R8]
            `ATF_SEL_CMP:    trig_cur = trig_flags_in[1];         // [R8]
            `ATF_SEL_EXT0:   trig_cur = trig_flags_in[2];         // [R8]
            `ATF_SEL_T0CMPA: trig_cur = trig_flags_in[3];         // [R8]
            `ATF_SEL_T0OVF:  trig_cur = trig_flags_in[4];         // [R8]
            `ATF_SEL_T1CMPB: trig_cur = trig_flags_in[5];         // [R8]
            `ATF_SEL_T1OVF:  trig_cur = trig_flags_in[6];         // [R8]
            `ATF_SEL_T1CAP:  trig_cur = trig_flags_in[7];         // [R8]
        endcase
    end

    // A move onto the free-running code must not look like an edge,
    // even though the done flag may already sit high
    assign to_free = (st_r.ctrl_b[`ATF_B_SEL] == `ATF_SEL_FREE)
                  && (st_r.prev_sel != `ATF_SEL_FREE);            // [R7]

    // Edge against the stored copy; a source switch shows up the same way
    assign trig_fire = trig_cur && !st_r.prev_trig && !to_free    // [R15] [R6]
                    && st_r.ctrl_a[`ATF_A_AUTO]                   // [R4] [R12]
                    && st_r.ctrl_a[`ATF_A_ENABLE];                // [R5]

    // Software start: start bit written with enable in the same value
    assign sw_start = bus.wr && (bus.addr == `ATF_OFS_CTRL_A)
                   && bus.wdata[`ATF_A_START]
                   && bus.wdata[`ATF_A_ENABLE];

    // Result bytes formed live from the stored result, so a flip of
    // the alignment bit is seen mid-conversion with no extra state
    always_comb begin
        if (st_r.ctrl_b[`ATF_B_LEFT]) begin                       // [R1] [R2]
            res_hi = st_r.result[9:2];                            // [R13]
            res_lo = {st_r.result[1:0], 6'h00};                   // [R13]
        end else begin
            res_hi = {6'h00, st_r.result[9:8]};                   // [R13]
            res_lo = st_r.result[7:0];
        end
    end

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;

        // Edge history follows the selection every cycle
        st_nxt.prev_trig = trig_cur;                              // [R15]
        st_nxt.prev_sel  = st_r.ctrl_b[`ATF_B_SEL];

        // Register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `ATF_OFS_CTRL_A: begin
                    st_nxt.ctrl_a[`ATF_A_ENABLE] = bus.wdata[`ATF_A_ENABLE];
                    st_nxt.ctrl_a[`ATF_A_AUTO]   = bus.wdata[`ATF_A_AUTO];
                    st_nxt.ctrl_a[`ATF_A_IE]     = bus.wdata[`ATF_A_IE];
                    st_nxt.ctrl_a[`ATF_A_PRESC]  = bus.wdata[`ATF_A_PRESC];
                    // Done flag clears by writing a one
                    if (bus.wdata[`ATF_A_DONE]) begin
                        st_nxt.ctrl_a[`ATF_A_DONE] = 1'b0;
                    end
                end
                `ATF_OFS_CTRL_B: begin
                    st_nxt.ctrl_b = bus.wdata;                    // [R3]
                end
                `ATF_OFS_PIN_OFF: begin
                    st_nxt.pin_off = bus.wdata;                   // [R9]
                end
                default: begin
                end
            endcase
        end

        // Start pulse; a busy converter ignores further requests
        st_nxt.start = (sw_start || trig_fire)
                    && !st_r.ctrl_a[`ATF_A_START];                // [R5] [R12]
        if (st_nxt.start) begin
            st_nxt.ctrl_a[`ATF_A_START] = 1'b1;
        end

        // Completion: flag set beats a same-cycle clear
        if (conv_done_in && st_r.ctrl_a[`ATF_A_ENABLE]) begin
            st_nxt.ctrl_a[`ATF_A_START] = 1'b0;
            st_nxt.ctrl_a[`ATF_A_DONE]  = 1'b1;
            // Held pair drops the new result rather than tearing it
            if (!st_r.locked) begin                               // [R14]
                st_nxt.result = conv_result_in;
            end
        end

        // Turning the converter off ends any conversion in flight
        if (!st_nxt.ctrl_a[`ATF_A_ENABLE]) begin
            st_nxt.ctrl_a[`ATF_A_START] = 1'b0;
            st_nxt.start                = 1'b0;
        end

        // Register reads, answered one cycle later
        st_nxt.rdata = `ATF_RST_BYTE;
        if (bus.rd) begin
            unique case (bus.addr)
                `ATF_OFS_CTRL_A:  st_nxt.rdata = st_r.ctrl_a;
                `ATF_OFS_CTRL_B:  st_nxt.rdata = st_r.ctrl_b;     // [R3]
                `ATF_OFS_PIN_OFF: st_nxt.rdata = st_r.pin_off;
                `ATF_OFS_RES_HI: begin
                    st_nxt.rdata  = res_hi;                       // [R1]
                    st_nxt.locked = 1'b0;                         // [R14]
                end
                `ATF_OFS_RES_LO: begin
                    st_nxt.rdata  = res_lo;                       // [R1]
                    st_nxt.locked = 1'b1;                         // [R14]
                end
                default:          st_nxt.rdata = `ATF_RST_BYTE;
            endcase
        end

        // Pin inputs: two-stage sync, then gate by the disable bits
        st_nxt.pin_s1 = pin_level_in;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_rd = st_r.pin_s2 & ~st_r.pin_off;              // [R10]
    end

    // State register
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= '{ctrl_a:    `ATF_RST_BYTE,
                      ctrl_b:    `ATF_RST_BYTE,
                      pin_off:   `ATF_RST_BYTE,
                      result:    `ATF_RST_RES,
                      locked:    1'b0,
                      prev_trig: 1'b0,
                      prev_sel:  `ATF_SEL_FREE,
                      start:     1'b0,
                      rdata:     `ATF_RST_BYTE,
                      pin_s1:    `ATF_RST_BYTE,
                      pin_s2:    `ATF_RST_BYTE,
                      pin_rd:    `ATF_RST_BYTE};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign rd_data_out               = st_r.rdata;
    assign conv_enable_out           = st_r.ctrl_a[`ATF_A_ENABLE];
    assign conv_start_out            = st_r.start;
    assign conv_prescale_out         = st_r.ctrl_a[`ATF_A_PRESC];
    assign conv_bipolar_out          = st_r.ctrl_b[`ATF_B_BIPOLAR];
    assign comparator_mux_select_out = st_r.ctrl_b[`ATF_B_CMP_MUX];
    assign conversion_done_flag_out  = st_r.ctrl_a[`ATF_A_DONE];
    assign analog_pin_input_off_out  = st_r.pin_off;              // [R9]
    assign pin_read_out              = st_r.pin_rd;

    // Checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!reset_n_in);

    sequence s_wr_b;
        bus.wr && bus.addr == `ATF_OFS_CTRL_B;
    endsequence

    sequence s_rd_b;
        bus.rd && bus.addr == `ATF_OFS_CTRL_B;
    endsequence

    sequence s_rd_hi;
        bus.rd && bus.addr == `ATF_OFS_RES_HI;
    endsequence

    sequence s_rd_lo;
        bus.rd && bus.addr == `ATF_OFS_RES_LO;
    endsequence

    AST_ALIGN_LEFT: assert property (  // [R1] [R13]
        s_rd_hi and st_r.ctrl_b[`ATF_B_LEFT]
        |=> rd_data_out == $past(st_r.result[9:2]))
        else $error("left aligned high byte wrong");

    AST_ALIGN_RIGHT: assert property (  // [R1] [R13]
        s_rd_lo and !st_r.ctrl_b[`ATF_B_LEFT]
        |=> rd_data_out == $past(st_r.result[7:0]))
        else $error("right aligned low byte wrong");

    AST_ALIGN_LIVE: assert property (  // [R2]
        (s_wr_b ##1 (s_rd_hi and st_r.ctrl_a[`ATF_A_START]))
        |=> rd_data_out == ($past(bus.wdata[`ATF_B_LEFT], 2)
            ? $past(st_r.result[9:2])
            : {6'h00, $past(st_r.result[9:8])}))
        else $error("alignment change not seen at once");

    AST_RESV_STORE: assert property (  // [R3]
        (s_wr_b ##1 s_rd_b)
        |=> rd_data_out[5] == $past(bus.wdata[5], 2)
            && rd_data_out[3] == $past(bus.wdata[3], 2))
        else $error("reserved bits not stored");

    AST_NO_AUTO: assert property (  // [R4]
        conv_start_out && !$past(st_r.ctrl_a[`ATF_A_AUTO])
        |-> $past(sw_start))
        else $error("start without auto trigger or software");

    AST_EDGE_START: assert property (  // [R5] [R12] [R15]
        st_r.ctrl_a[`ATF_A_AUTO] && st_r.ctrl_a[`ATF_A_ENABLE]
        && !st_r.ctrl_a[`ATF_A_START] && !to_free
        && trig_cur && !st_r.prev_trig && !(bus.wr && !wr_data_in[7]
        && bus.addr == `ATF_OFS_CTRL_A)
        |=> conv_start_out ##1 !conv_start_out)
        else $error("trigger edge gave no single start pulse");

    AST_SWITCH: assert property (  // [R6]
        $changed(st_r.ctrl_b[`ATF_B_SEL]) && !st_r.prev_trig && trig_cur
        && !to_free && st_r.ctrl_a[`ATF_A_AUTO]
        && st_r.ctrl_a[`ATF_A_ENABLE]
        |-> trig_fire)
        else $error("source switch edge missed");

    AST_FREE_SWITCH: assert property (  // [R7]
        to_free && !sw_start |=> !conv_start_out)
        else $error("switch to free running triggered");

    AST_DECODE: assert property (  // [R8]
        st_r.ctrl_b[`ATF_B_SEL] == `ATF_SEL_T1CAP
        |-> trig_cur == trig_flags_in[7])
        else $error("trigger source decode wrong");

    AST_PIN_MASK: assert property (  // [R9] [R10]
        ##1 ((pin_read_out & $past(analog_pin_input_off_out)) == 8'h00))
        else $error("disabled pin did not read zero");

    AST_LOCK: assert property (  // [R14]
        st_r.locked && !bus.rd ##1 conv_done_in
        |=> st_r.result == $past(st_r.result))
        else $error("result updated while pair held");

    // A free pair takes every finished result
    sequence s_done_free;
        !st_r.locked && conv_done_in && st_r.ctrl_a[`ATF_A_ENABLE];
    endsequence

    AST_UNLOCK: assert property (  // [R14]
        s_done_free |=> st_r.result == $past(conv_result_in))
        else $error("result not taken while pair free");

    // Disable bits reach the pin buffers the cycle after the write
    sequence s_wr_pin;
        bus.wr && bus.addr == `ATF_OFS_PIN_OFF;
    endsequence

    AST_PIN_OFF: assert property (  // [R9]
        s_wr_pin |=> analog_pin_input_off_out == $past(bus.wdata))
        else $error("input disable write not applied");

    // A busy converter must not see a second start
    AST_BUSY: assert property (  // [R5] [R12]
        st_r.ctrl_a[`ATF_A_START] |=> !conv_start_out)
        else $error("start pulse while converter busy");

endmodule : atf_top
